// file: i2c_ctrl_model.sv
// Two-wire bus controller model: drives SCL, pulls SDA low.
// Assumes the bench resolves SDA with a pull-up from all enables.
module i2c_ctrl_model (
  // Clock and wire
  input  wire logic clock,
  input  wire logic sdaWire,
  // Bus drive
  output logic      scl,
  output logic      sdaLow
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idles released
  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end
  // Wait n falling clock edges
  task automatic q(input int n);
    repeat (n) @(negedge clock);
  endtask
  // One bit: set mid-low, sampled mid-high
  task automatic bitIo(input logic v, output logic r);
    q(4);
    sdaLow = !v;
    q(4);
    scl = 1'b1;
    q(4);
    r = sdaWire;
    q(4);
    scl = 1'b0;
  endtask
  // Start, also a repeated start
  task automatic startC;
    sdaLow = 1'b0;
    q(4);
    scl = 1'b1;
    q(8);
    sdaLow = 1'b1;
    q(8);
    scl = 1'b0;
  endtask
  // Stop, then bus left idle
  task automatic stopC;
    q(4);
    sdaLow = 1'b1;
    q(4);
    scl = 1'b1;
    q(8);
    sdaLow = 1'b0;
    q(8);
  endtask
  // Byte out or in, MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] b, input logic rd, input logic mAck,
                      output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bitIo(rd | b[i], r[i]);
    bitIo(rd ? !mAck : 1'b1, ack);
    ack = !ack;
  endtask
endmodule

// file: signal_sync2.sv
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; multi-bit codes may skew by a cycle.
module signal_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  logic             clock,
  input  logic             rst,
  // Levels
  input  logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  ////////////////////////////////////////////////////////////////////////
  // One pair of flops per bit
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic stage1_r;  // First stage, read only by the second
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          stage1_r     <= 1'b0;
          syncOut[gi]  <= 1'b0;
        end else begin
          stage1_r     <= asyncIn[gi];
          syncOut[gi]  <= stage1_r;
        end
      end
    end
  endgenerate

endmodule

// file: synth_i2c_control_interface.sv
// Two-wire control and status interface of a tuner frequency synthesiser.
// Assumes SCL/SDA and all analog-side levels are asynchronous to clock.
//
// Contract
// - Address low bit picks write or read
// - Accept selectable address variant from select port
// - Acknowledge matching address and every written byte
// - Missing read acknowledge acts as stop
// - First bit zero frequency, one control
// - Frequency pairs with frequency, control with port
// - Further pairs accepted until bus stop
// - Partial byte discarded, old value kept
// - Frequency bytes load fifteen-bit divider ratio
// - Divider follows fixed divide-by-sixteen prescaler
// - Reference select one gives 512, zero 1024
// - Pump current select, forced low when locked
// - Pump disable bit disables charge pump
// - Drive-off bit switches drive amplifier off
// - Test enable gates mode bits five-seven
// - Port bit one turns port on
// - Power-on flag set by dropout, cleared reading
// - Power-on flag loses data, ports off
// - Status lock bit reports phase lock
// - Status bits report ports seven, five, four
// - Status low bits carry converter code
// - Address fixed 11000, variant, direction
// - Control byte field layout from first bit
// - Test modes force pump or route ports
// - Converter code ranges 000 to 100
`include "synth_i2c_defines.svh"

module synth_i2c_control_interface (
  // Clock and reset
  input  logic                       clock,
  input  logic                       rst,
  // Serial link, open drain data
  input  logic                       sclIn,
  input  logic                       sdaIn,
  output logic                       sdaOut,
  output logic                       sdaDriveN,
  // Analog-side levels
  input  logic [1:0]                 addrVariant,
  input  logic                       porEvent,
  input  logic                       lockRaw,
  input  logic [2:0]                 portLevelIn,
  input  logic [2:0]                 convCodeIn,
  // Synthesiser controls
  output logic [`SI_DIV_W-1:0]       dividerRatio,
  output logic                       refDivide512,
  output logic                       pumpCurrentHigh,
  output logic                       pumpOff,
  output logic                       driveAmpOff,
  output logic                       pumpForceSource,
  output logic                       pumpForceSink,
  output synth_i2c_pkg::route_t      portSevenRoute,
  output logic                       portSixRoute,
  // Ports and flags
  output logic [`SI_PORT_W-1:0]      portDriveN,
  output logic                       porFlag
);
  import synth_i2c_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [`SI_SYNC_W-1:0] syncBus;        // Synchronised inputs
  logic                  sclS;           // Sampled clock line
  logic                  sdaS;           // Sampled data line
  logic [1:0]            addrVarS;       // Sampled address variant
  logic                  porS;           // Sampled dropout level
  logic                  lockS;          // Sampled lock detect
  logic [2:0]            portLvlS;       // Sampled port levels
  logic [2:0]            convS;          // Sampled converter code
  logic                  sclD_r;         // Previous clock sample
  logic                  sdaD_r;         // Previous data sample
  logic                  sclRise;        // Clock rising
  logic                  sclFall;        // Clock falling
  logic                  startSeen;      // Start condition
  logic                  stopSeen;       // Stop condition
  link_state_t           state_r;        // Link state
  link_state_t           state_nxt;      // Next link state
  logic [2:0]            bitCnt_r;       // Bits of current byte
  logic                  byteFull_r;     // Eight bits clocked
  logic [7:0]            shift_r;        // Receive shifter
  logic [7:0]            rxByte;         // Shifter with newest bit
  logic                  addrOk_r;       // Address matched
  logic                  rw_r;           // Read direction
  logic                  commit;         // Whole write byte present
  logic                  pairPending_r;  // Second byte expected
  logic                  pairKind_r;     // Zero frequency, one control
  logic [`SI_DIV_W-1:0]  divider_r;      // Divider ratio register
  loop_ctrl_t            loopCtrl_r;     // Loop control register
  port_ctrl_t            portCtrl_r;     // Port control register
  logic [7:0]            tx_r;           // Transmit shifter
  logic [7:0]            tx_nxt;         // Next transmit shifter
  logic                  sdaDriveN_r;    // Data line release
  logic                  readSeen_r;     // Read phase in this transfer
  logic                  porFlag_r;      // Power-on flag
  logic                  lockFlag;       // Reported lock
  logic [2:0]            convSat;        // Clamped converter code
  status_t               statusNow;      // Live status byte
  logic                  testSource;     // Test pump source mode
  logic                  testSink;       // Test pump sink mode

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  signal_sync2 #(.WIDTH(`SI_SYNC_W)) u_sync (
    .clock   (clock),
    .rst     (rst),
    .asyncIn ({sclIn, sdaIn, addrVariant, porEvent, lockRaw, portLevelIn, convCodeIn}),
    .syncOut (syncBus)
  );
  assign {sclS, sdaS, addrVarS, porS, lockS, portLvlS, convS} = syncBus;

  // Delayed samples for edge and condition detect
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclD_r <= 1'b0;
      sdaD_r <= 1'b0;
    end else begin
      sclD_r <= sclS;
      sdaD_r <= sdaS;
    end
  end

  assign sclRise   = sclS & ~sclD_r;
  assign sclFall   = ~sclS & sclD_r;
  assign startSeen = sclS & sclD_r & sdaD_r & ~sdaS;
  assign stopSeen  = sclS & sclD_r & ~sdaD_r & sdaS;
  assign rxByte    = {shift_r[`SI_SER_SHIFT_RANGE], sdaS};

  ////////////////////////////////////////////////////////////////////////
  // Link state machine
  always_comb begin
    state_nxt = state_r;
    if (stopSeen) begin
      state_nxt = ST_IDLE;
    end else if (startSeen) begin
      state_nxt = ST_ADDR;
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_nxt = ST_IDLE;
        end
        ST_ADDR: begin
          // Ack only a matching address
          if (sclFall && byteFull_r) begin
            state_nxt = addrOk_r ? ST_ADDR_ACK : ST_IDLE;
          end
        end
        ST_ADDR_ACK: begin
          // Direction from address low bit
          if (sclFall) begin
            state_nxt = rw_r ? ST_READ : ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (sclFall && byteFull_r) begin
            state_nxt = ST_WRITE_ACK;
          end
        end
        ST_WRITE_ACK: begin
          // Keep taking bytes until stop
          if (sclFall) begin
            state_nxt = ST_WRITE;
          end
        end
        ST_READ: begin
          if (sclFall && byteFull_r) begin
            state_nxt = ST_READ_ACK;
          end
        end
        ST_READ_ACK: begin
          // No ack acts as internal stop
          if (sclRise && sdaS) begin
            state_nxt = ST_IDLE;
          end else if (sclFall) begin
            state_nxt = ST_READ;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit counter and receive shifter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bitCnt_r   <= `SI_BIT_ZERO;
      byteFull_r <= 1'b0;
      shift_r    <= `SI_BYTE_ZERO;
    end else if (state_nxt != state_r || startSeen) begin
      // New byte slot, partial bits dropped
      bitCnt_r   <= `SI_BIT_ZERO;
      byteFull_r <= 1'b0;
    end else if (sclRise && (state_r == ST_ADDR || state_r == ST_WRITE
                             || state_r == ST_READ)) begin
      shift_r    <= rxByte;
      bitCnt_r   <= bitCnt_r + 3'h1;
      byteFull_r <= (bitCnt_r == `SI_BIT_LAST);
    end
  end

  // Address match on the eighth bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addrOk_r <= 1'b0;
      rw_r     <= 1'b0;
    end else if (sclRise && state_r == ST_ADDR && bitCnt_r == `SI_BIT_LAST) begin
      addrOk_r <= (rxByte[`SI_ADDR_FIX_RANGE] == `SI_ADDR_FIXED)
                  && (rxByte[`SI_ADDR_VAR_RANGE] == addrVarS
                      || rxByte[`SI_ADDR_VAR_RANGE] == `SI_ADDR_VAR_ALWAYS);
      rw_r     <= rxByte[`SI_RW_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write byte decoding
  assign commit = sclRise && state_r == ST_WRITE && bitCnt_r == `SI_BIT_LAST;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pairPending_r <= 1'b0;
      pairKind_r    <= 1'b0;
      divider_r     <= `SI_DIV_ZERO;
      loopCtrl_r    <= loop_ctrl_t'(`SI_BYTE_ZERO);
      portCtrl_r    <= port_ctrl_t'(`SI_BYTE_ZERO);
    end else if (porS) begin
      // Dropout loses programmed data
      pairPending_r <= 1'b0;
      divider_r     <= `SI_DIV_ZERO;
      loopCtrl_r    <= loop_ctrl_t'(`SI_BYTE_ZERO);
      portCtrl_r    <= port_ctrl_t'(`SI_BYTE_ZERO);
    end else if (startSeen || stopSeen) begin
      pairPending_r <= 1'b0;
    end else if (commit && !pairPending_r) begin
      // First bit picks the byte pair
      pairPending_r <= 1'b1;
      pairKind_r    <= rxByte[`SI_FIRST_BIT];
      if (!rxByte[`SI_FIRST_BIT]) begin
        divider_r[`SI_DIV_HI_RANGE] <= rxByte[`SI_FREQ_HI_RANGE];
      end else begin
        loopCtrl_r <= loop_ctrl_t'(rxByte);
      end
    end else if (commit) begin
      // Second byte of the pair
      pairPending_r <= 1'b0;
      if (!pairKind_r) begin
        divider_r[`SI_DIV_LO_RANGE] <= rxByte;
      end else begin
        portCtrl_r <= port_ctrl_t'(rxByte);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status assembly
  always_comb begin
    testSource = loopCtrl_r.testEnable && !loopCtrl_r.modeSelectHigh
                 && !loopCtrl_r.modeSelectMid;
    testSink   = loopCtrl_r.testEnable && !loopCtrl_r.modeSelectHigh
                 && loopCtrl_r.modeSelectMid;
    // Forced flag in pump test modes
    lockFlag   = testSink ? 1'b1 : (testSource ? 1'b0 : lockS);
    // Codes beyond top band clamp to top
    convSat    = (convS > `SI_CONV_MAX) ? `SI_CONV_MAX : convS;
    statusNow  = '{porFlag:        porFlag_r,
                   lockIndicator:  lockFlag,
                   portSevenLevel: portLvlS[2],
                   portFiveLevel:  portLvlS[1],
                   portFourLevel:  portLvlS[0],
                   convCode:       convSat};
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit shifter and data line drive
  always_comb begin
    tx_nxt = tx_r;
    if (state_nxt == ST_READ && state_r != ST_READ) begin
      tx_nxt = statusNow;
    end else if (state_r == ST_READ && sclFall) begin
      tx_nxt = {tx_r[`SI_SER_SHIFT_RANGE], 1'b0};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_r        <= `SI_BYTE_ZERO;
      sdaDriveN_r <= 1'b1;
    end else begin
      tx_r        <= tx_nxt;
      // Pull low in address and write ack slots and for zero read bits
      sdaDriveN_r <= !((state_nxt == ST_ADDR_ACK) || (state_nxt == ST_WRITE_ACK)
                       || (state_nxt == ST_READ && !tx_nxt[`SI_SER_MSB]));
    end
  end

  assign sdaOut    = 1'b0;
  assign sdaDriveN = sdaDriveN_r;

  ////////////////////////////////////////////////////////////////////////
  // Power-on flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      readSeen_r <= 1'b0;
    end else if (stopSeen) begin
      readSeen_r <= 1'b0;
    end else if (state_nxt == ST_READ) begin
      readSeen_r <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      porFlag_r <= 1'b1;
    end else if (porS) begin
      porFlag_r <= 1'b1;
    end else if (stopSeen && readSeen_r) begin
      porFlag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Synthesiser and port outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dividerRatio    <= `SI_DIV_ZERO;
      refDivide512    <= 1'b0;
      pumpCurrentHigh <= 1'b0;
      pumpOff         <= 1'b0;
      driveAmpOff     <= 1'b0;
      pumpForceSource <= 1'b0;
      pumpForceSink   <= 1'b0;
      portSevenRoute  <= ROUTE_PORT;
      portSixRoute    <= 1'b0;
      portDriveN      <= `SI_PORTS_OFF;
      porFlag         <= 1'b1;
    end else begin
      // Ratio feeds the divider behind the fixed prescaler
      dividerRatio    <= divider_r;
      refDivide512    <= loopCtrl_r.refRatioSelect;
      pumpCurrentHigh <= loopCtrl_r.pumpCurrentSelect && !lockS;
      pumpOff         <= loopCtrl_r.pumpDisable;
      driveAmpOff     <= loopCtrl_r.driveAmpOff;
      // Mode bits act only with test enable
      pumpForceSource <= testSource;
      pumpForceSink   <= testSink;
      if (loopCtrl_r.testEnable && loopCtrl_r.modeSelectHigh) begin
        portSevenRoute <= loopCtrl_r.modeSelectMid ? ROUTE_FPD
                        : (loopCtrl_r.refRatioSelect ? ROUTE_FPD_HALF : ROUTE_PORT);
        portSixRoute   <= loopCtrl_r.modeSelectMid;
      end else begin
        portSevenRoute <= ROUTE_PORT;
        portSixRoute   <= 1'b0;
      end
      // Ports off while flag set; unused bits skipped
      if (porFlag_r) begin
        portDriveN <= `SI_PORTS_OFF;
      end else begin
        portDriveN <= ~{portCtrl_r.ioPortSeven, portCtrl_r.ioPortSix,
                        portCtrl_r.ioPortFive, portCtrl_r.ioPortFour,
                        portCtrl_r.currentPortThree, portCtrl_r.currentPortZero};
      end
      porFlag <= porFlag_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_DIRECTION: assert property (
    (state_r == ST_ADDR_ACK && sclFall && !rw_r) |=> state_r == ST_WRITE)
    else $error("write address did not enter write state");

  AST_ADDR_ACK: assert property (
    (state_r == ST_ADDR && sclFall && byteFull_r && addrOk_r) |=>
      (state_r == ST_ADDR_ACK && !sdaDriveN))
    else $error("matching address not acknowledged");

  AST_ADDR_IGNORE: assert property (
    (state_r == ST_ADDR && sclFall && byteFull_r && !addrOk_r) |=>
      (state_r == ST_IDLE && sdaDriveN) [*2])
    else $error("foreign address acknowledged");

  AST_WRITE_ACK: assert property (
    (state_r == ST_WRITE && sclFall && byteFull_r) |=> !sdaDriveN)
    else $error("write byte not acknowledged");

  AST_NACK_STOP: assert property (
    (state_r == ST_READ_ACK && sclRise && sdaS) |=> (state_r == ST_IDLE && sdaDriveN))
    else $error("transmit continued after missing acknowledge");

  AST_FREQ_FIRST: assert property (
    (commit && !pairPending_r && !rxByte[`SI_FIRST_BIT] && !porS && !startSeen) |=>
      (divider_r[`SI_DIV_HI_RANGE] == $past(rxByte[`SI_FREQ_HI_RANGE])
       && pairPending_r && !pairKind_r))
    else $error("first frequency byte not loaded");

  AST_PAIR_SECOND: assert property (
    (commit && pairPending_r && pairKind_r && !porS) |=>
      (portCtrl_r == $past(rxByte) && !pairPending_r))
    else $error("port byte not paired with control byte");

  AST_PARTIAL_KEEP: assert property (
    (stopSeen && !porS) |=> ($stable(divider_r) && $stable(portCtrl_r) && $stable(loopCtrl_r)))
    else $error("stop changed programmed data");

  AST_POR_CLEAR: assert property (
    (stopSeen && readSeen_r && !porS) |=> ##1 !porFlag)
    else $error("power-on flag not cleared by read stop");

  AST_POR_PORTS: assert property (
    porFlag_r |=> portDriveN == `SI_PORTS_OFF)
    else $error("port driven while power-on flag set");

  AST_LOCK_CURRENT: assert property (
    lockS |=> !pumpCurrentHigh)
    else $error("high pump current while locked");

  COV_WRITE_PAIR: cover property (commit && pairPending_r);
  COV_READ_ACKED: cover property (state_r == ST_READ_ACK && sclFall);
  COV_READ_NACK:  cover property (state_r == ST_READ_ACK && sclRise && sdaS);
  COV_POR_CLEAR:  cover property (stopSeen && readSeen_r);

endmodule

// file: synth_i2c_control_interface_tb_top.sv
// Bench of the synthesiser control interface.
// Assumes the controller model drives the link at a 160 ns SCL period.
`include "synth_i2c_defines.svh"
module synth_i2c_control_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import synth_i2c_pkg::*;
  ////////////////////////////////////////////////////////////////
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic                 scl, sdaLow, sdaOut, sdaDriveN, ak;
  logic [1:0]           addrVariant;
  logic                 porEvent, lockRaw, ref512, cpHi, pOff, aOff;
  logic [2:0]           portLevelIn, convCodeIn;
  logic [`SI_DIV_W-1:0] divR;
  logic                 fSrc, fSnk, p6Route, por;
  route_t               p7Route;
  logic [5:0]           portN;
  logic [7:0]           rb;
  int                   n_fail, cmp_count;
  // Rows: control, port, {ref,cp,off,amp,src,sink}, port drives
  logic [27:0]          rows [5] = '{{8'hCE, 8'h01, 6'h30, 6'h3E},
    {8'h9F, 8'hF8, 6'h2C, 6'h01}, {8'h8C, 8'h06, 6'h00, 6'h3F},
    {8'hA0, 8'h00, 6'h02, 6'h3F}, {8'hA4, 8'h00, 6'h01, 6'h3F}};
  wire                  sdaWire = !sdaLow & sdaDriveN;
  always #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////
  synth_i2c_control_interface i_dut (.clock(clock), .rst(rst), .sclIn(scl),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaDriveN(sdaDriveN),
    .addrVariant(addrVariant), .porEvent(porEvent), .lockRaw(lockRaw),
    .portLevelIn(portLevelIn), .convCodeIn(convCodeIn), .dividerRatio(divR),
    .refDivide512(ref512), .pumpCurrentHigh(cpHi), .pumpOff(pOff),
    .driveAmpOff(aOff), .pumpForceSource(fSrc), .pumpForceSink(fSnk),
    .portSevenRoute(p7Route), .portSixRoute(p6Route), .portDriveN(portN),
    .porFlag(por));
  i2c_ctrl_model i_ctrl (.clock(clock), .sdaWire(sdaWire), .scl(scl),
    .sdaLow(sdaLow));
  ////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    summarize();
  end
  // Main sequence
  initial begin
    // No dropout, locked, variant 10, ports 101, converter code 7
    {porEvent, lockRaw, addrVariant, portLevelIn, convCodeIn} = 10'h1AF;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    i_ctrl.q(8);
    chk(por, 1'b1);
    chk(portN, 6'h3F);
    chk(sdaOut, 1'b0);
    i_ctrl.startC();
    i_ctrl.xfer(8'hC6, 1'b0, 1'b0, rb, ak);
    chk(ak, 1'b0);
    i_ctrl.startC();
    i_ctrl.xfer(8'hC4, 1'b0, 1'b0, rb, ak);
    chk(ak, 1'b1);
    i_ctrl.startC();
    i_ctrl.xfer(8'hC3, 1'b0, 1'b0, rb, ak);
    chk(ak, 1'b1);
    i_ctrl.xfer(8'h00, 1'b1, 1'b1, rb, ak);
    chk(rb, 8'hEC);
    i_ctrl.xfer(8'h00, 1'b1, 1'b0, rb, ak);
    chk(rb, 8'hEC);
    i_ctrl.stopC();
    chk(por, 1'b0);
    lockRaw = 1'b0;
    // Control and port pairs, one transfer per row
    for (int i = 0; i < 5; i++) begin
      i_ctrl.startC();
      i_ctrl.xfer(8'hC2, 1'b0, 1'b0, rb, ak);
      i_ctrl.xfer(rows[i][27:20], 1'b0, 1'b0, rb, ak);
      chk(ak, 1'b1);
      i_ctrl.xfer(rows[i][19:12], 1'b0, 1'b0, rb, ak);
      i_ctrl.stopC();
      chk({ref512, cpHi, pOff, aOff, fSrc, fSnk}, rows[i][11:6]);
      chk(portN, rows[i][5:0]);
      chk({p7Route, p6Route}, 3'h0);
    end
    // Routing test modes: half phase-detector, then full with port six
    for (int i = 0; i < 2; i++) begin
      i_ctrl.startC();
      i_ctrl.xfer(8'hC2, 1'b0, 1'b0, rb, ak);
      i_ctrl.xfer(i ? 8'hEE : 8'hAA, 1'b0, 1'b0, rb, ak);
      i_ctrl.xfer(8'h00, 1'b0, 1'b0, rb, ak);
      i_ctrl.stopC();
      chk({p7Route, p6Route}, i ? {ROUTE_FPD, 1'b1} : {ROUTE_FPD_HALF, 1'b0});
    end
    // Back-to-back pairs, locked, then a broken byte
    lockRaw = 1'b1;
    i_ctrl.startC();
    i_ctrl.xfer(8'hC2, 1'b0, 1'b0, rb, ak);
    i_ctrl.xfer(8'h2A, 1'b0, 1'b0, rb, ak);
    i_ctrl.xfer(8'h55, 1'b0, 1'b0, rb, ak);
    i_ctrl.xfer(8'hCE, 1'b0, 1'b0, rb, ak);
    i_ctrl.xfer(8'h01, 1'b0, 1'b0, rb, ak);
    for (int i = 0; i < 3; i++) i_ctrl.bitIo(1'b0, rb[i]);
    i_ctrl.stopC();
    chk(divR, 15'h2A55);
    chk({ref512, cpHi, portN}, {2'h2, 6'h3E});
    lockRaw = 1'b0;
    i_ctrl.q(8);
    chk(cpHi, 1'b1);
    // Supply dropout
    porEvent = 1'b1;
    i_ctrl.q(8);
    chk({por, portN, divR}, {1'b1, 6'h3F, 15'h0000});
    summarize();
  end
endmodule

// file: synth_i2c_defines.svh
// Numeric constants of the synthesiser control interface.
// Assumes inclusion by bare name from the design files.
`ifndef SYNTH_I2C_DEFINES_SVH
`define SYNTH_I2C_DEFINES_SVH
`define SI_ADDR_FIXED       5'h18
`define SI_ADDR_FIX_RANGE   7:3
`define SI_ADDR_VAR_RANGE   2:1
`define SI_ADDR_VAR_ALWAYS  2'h1
`define SI_RW_BIT           0
`define SI_FIRST_BIT        7
`define SI_SER_MSB          7
`define SI_SER_SHIFT_RANGE  6:0
`define SI_BIT_LAST         3'h7
`define SI_BIT_ZERO         3'h0
`define SI_DIV_W            15
`define SI_DIV_HI_RANGE     14:8
`define SI_DIV_LO_RANGE     7:0
`define SI_FREQ_HI_RANGE    6:0
`define SI_SYNC_W           12
`define SI_CONV_MAX         3'h4
`define SI_PORT_W           6
`define SI_PORTS_OFF        6'h3F
`define SI_BYTE_ZERO        8'h00
`define SI_DIV_ZERO         15'h0000
`define SI_MODE_SOURCE      2'h0
`define SI_MODE_SINK        2'h1
`endif

// file: synth_i2c_pkg.sv
// Types of the synthesiser control interface.
// Assumes no other package; numbers live in the defines header.
package synth_i2c_pkg;

  // Serial link states
  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_ADDR      = 3'h1,
    ST_ADDR_ACK  = 3'h2,
    ST_WRITE     = 3'h3,
    ST_WRITE_ACK = 3'h4,
    ST_READ      = 3'h5,
    ST_READ_ACK  = 3'h6
  } link_state_t;

  // Loop control byte, first-sent bit on the left
  typedef struct packed {
    logic ctrlMarker;
    logic pumpCurrentSelect;
    logic testEnable;
    logic pumpDisable;
    logic modeSelectHigh;
    logic modeSelectMid;
    logic refRatioSelect;
    logic driveAmpOff;
  } loop_ctrl_t;

  // Port control byte, first-sent bit on the left
  typedef struct packed {
    logic ioPortSeven;
    logic ioPortSix;
    logic ioPortFive;
    logic ioPortFour;
    logic currentPortThree;
    logic unusedHigh;
    logic unusedLow;
    logic currentPortZero;
  } port_ctrl_t;

  // Status readback byte, first-sent bit on the left
  typedef struct packed {
    logic       porFlag;
    logic       lockIndicator;
    logic       portSevenLevel;
    logic       portFiveLevel;
    logic       portFourLevel;
    logic [2:0] convCode;
  } status_t;

  // Test routing of port seven
  typedef enum logic [1:0] {
    ROUTE_PORT     = 2'h0,
    ROUTE_FPD_HALF = 2'h1,
    ROUTE_FPD      = 2'h2
  } route_t;

endpackage
